// [hdl/fpec_pkg.sv]
`default_nettype none
package fpec_pkg;

    // Register indices; each sits at byte address four times its index
    localparam logic [15:0] FPEC_IDX_ADDRESS = 16'h1C8C;
    localparam logic [15:0] FPEC_IDX_DATA = 16'h1C8E;
    localparam logic [15:0] FPEC_IDX_CONTROL = 16'h1C90;
    localparam logic [15:0] FPEC_IDX_UNLOCK = 16'h1C91;
    localparam logic [15:0] FPEC_BA_ADDRESS = {FPEC_IDX_ADDRESS[13:0], 2'b00};
    localparam logic [15:0] FPEC_BA_DATA = {FPEC_IDX_DATA[13:0], 2'b00};
    localparam logic [15:0] FPEC_BA_CONTROL = {FPEC_IDX_CONTROL[13:0], 2'b00};
    localparam logic [15:0] FPEC_BA_UNLOCK = {FPEC_IDX_UNLOCK[13:0], 2'b00};

    // Control register fields
    localparam int FPEC_CTL_READ = 0;
    localparam int FPEC_CTL_WRITE = 1;
    localparam int FPEC_CTL_ENABLE = 2;
    localparam int FPEC_CTL_ERROR = 3;
    localparam int FPEC_CTL_ERASE = 4;
    localparam int FPEC_CTL_LATCH = 5;
    localparam int FPEC_CTL_REGION = 6;
    localparam logic [7:0] FPEC_CTL_RESET = 8'h00;

    localparam logic [7:0] FPEC_KEY_FIRST = 8'h55;
    localparam logic [7:0] FPEC_KEY_SECOND = 8'hAA;

    localparam logic [13:0] FPEC_BLANK = 14'h3FFF;
    localparam logic [13:0] FPEC_DATA_RESET = 14'h0000;
    localparam logic [14:0] FPEC_ADDR_RESET = 15'h0000;
    localparam int FPEC_ROW_WORDS = 32;

    // Configuration region layout, as offsets within the region
    localparam logic [14:0] FPEC_CFG_UID_LAST = 15'h0003;
    localparam logic [14:0] FPEC_CFG_DEVID = 15'h0005;
    localparam logic [14:0] FPEC_CFG_REVID = 15'h0006;
    localparam logic [14:0] FPEC_CFG_WORD_FIRST = 15'h0007;
    localparam logic [14:0] FPEC_CFG_WORD_LAST = 15'h000B;
    localparam logic [14:0] FPEC_CFG_INFO_FIRST = 15'h0100;
    localparam logic [14:0] FPEC_CFG_INFO_LAST = 15'h02FF;
    localparam int FPEC_CFG_WORDS = 12;

    // Self-timed erase or program duration
    localparam int FPEC_CLK_PERIOD_NS = 10;
    localparam int FPEC_OP_TIME_NS = 2000;
    localparam int FPEC_OP_CYCLES = (FPEC_OP_TIME_NS + FPEC_CLK_PERIOD_NS - 1) / FPEC_CLK_PERIOD_NS;
    localparam int FPEC_CNT_W = $clog2(FPEC_OP_CYCLES + 1);

    typedef enum logic [1:0] {
        FPEC_IDLE,
        FPEC_LATCH,
        FPEC_ERASE,
        FPEC_PROGRAM
    } fpec_op_t;

    typedef enum logic [1:0] {
        FPEC_LOCKED,
        FPEC_GOT_FIRST,
        FPEC_ARMED
    } fpec_unlock_t;

endpackage
`default_nettype wire

// [hdl/fpec_top.sv]
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

//Contract
// - Write-start with a write-protected address sets the write-error flag; latch-only loads to a protected address do not set it here.
// - Reset during a self-timed erase or program sets the write-error flag.
// - Broken unlock sequence sets the error flag and starts nothing.
// - Software may set the error flag; only software clears it.
// - Erase-select erases the addressed 32-word row to ones, ignoring latch-only and data.
// - Protected erase or row write clears write-start and flags error, memory untouched.
// - Latch-only start copies data into the latch chosen by low address bits.
// - Row write programs all latches into the row, then latches go blank.
// - Region-select picks configuration/identification region when one, program flash when zero.
// - Program/erase enable zero inhibits every program and erase.
// - Operations are self-timed; hardware clears write-start on completion.
// - Writing zero to write-start does not disturb a running operation.
// - Read-start reads the addressed word into data; hardware clears it after.
// - Address bit 15 and error flag read undefined while writing.
// - Address register holds 15 bits, as high and low bytes.
// - Data register holds 14 bits, high byte bits 13:8, low byte 7:0.
// - Upper ten address bits pick the row, lower five the latch.
// - Configuration-region read of an invalid address returns zero.
// - Latches return to blank after every erase too.
module fpec_top import fpec_pkg::*; #(
    parameter int ADDR_W = 15,
    parameter logic [14:0] WP_LIMIT = 15'h0000,
    // Identity values are arbitrary
    parameter logic [13:0] DEV_ID = 14'h0123,
    parameter logic [13:0] REV_ID = 14'h0A01,
    parameter logic [13:0] INFO_WORD = 14'h0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    localparam int PROG_WORDS = 2 ** ADDR_W;

    logic [14:0] flash_address;
    logic [13:0] flash_data;
    logic region_select;
    logic latch_only;
    logic erase_select;
    logic write_error_flag;
    logic program_erase_enable;
    logic write_start;
    logic read_start;

    fpec_op_t op_state;
    fpec_unlock_t unlock_state;
    logic [FPEC_CNT_W-1:0] op_cnt;
    logic [9:0] op_row;
    logic op_region;
    logic [4:0] op_word;
    logic first_cycle;
    logic busy_mark = 1'b0;

    logic [13:0] latch_mem [0:FPEC_ROW_WORDS-1];
    logic [13:0] prog_mem [0:PROG_WORDS-1];
    logic [13:0] cfg_mem [0:FPEC_CFG_WORDS-1];

    logic setup;
    logic access;
    logic wr_acc;
    logic sel_addr;
    logic sel_data;
    logic sel_ctl;
    logic sel_unl;
    logic ctl_wr;
    logic key_first;
    logic key_second;
    logic wr_req;
    logic start_ok;
    logic unlock_err;
    logic new_free;
    logic new_latch;
    logic new_region;
    logic start;
    logic latch_sel;
    logic target_prot;
    logic prot_err;
    logic start_mem;
    logic latch_load;
    logic rd_req;
    logic mem_busy;
    logic mem_step;
    logic op_last;
    logic reset_err;
    logic [14:0] step_addr;
    logic [ADDR_W-1:0] prog_idx;
    logic [13:0] next_read;
    logic [31:0] next_prdata;

    function automatic logic cfg_writable(input logic [14:0] a);
        cfg_writable = (a <= FPEC_CFG_UID_LAST) || (a >= FPEC_CFG_WORD_FIRST && a <= FPEC_CFG_WORD_LAST);
    endfunction

    // Bus decode; zero wait states so every access completes in one access cycle
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr_acc = access & pwrite;
    assign sel_addr = (paddr == FPEC_BA_ADDRESS);
    assign sel_data = (paddr == FPEC_BA_DATA);
    assign sel_ctl = (paddr == FPEC_BA_CONTROL);
    assign sel_unl = (paddr == FPEC_BA_UNLOCK);
    assign pready = 1'b1;
    assign pslverr = access & ~(sel_addr | sel_data | sel_ctl | sel_unl);

    assign ctl_wr = wr_acc & sel_ctl & pstrb[0];
    // Zero written to write-start is simply not a request
    assign wr_req = ctl_wr & pwdata[FPEC_CTL_WRITE] & ~write_start;
    assign key_first = wr_acc & sel_unl & pstrb[0] & (pwdata[7:0] == FPEC_KEY_FIRST);
    assign key_second = wr_acc & sel_unl & pstrb[0] & (pwdata[7:0] == FPEC_KEY_SECOND)
        & (unlock_state == FPEC_GOT_FIRST);
    assign start_ok = wr_req & (unlock_state == FPEC_ARMED);

    // Any completed access that does not continue a begun sequence breaks it
    assign unlock_err = access & (((unlock_state != FPEC_LOCKED) & ~key_second & ~start_ok)
        | ((unlock_state == FPEC_LOCKED) & wr_req));

    // Operation selection uses the control value being written together with the start
    assign new_free = erase_select | pwdata[FPEC_CTL_ERASE];
    assign new_latch = pwdata[FPEC_CTL_LATCH];
    assign new_region = pwdata[FPEC_CTL_REGION];
    assign start = start_ok & pwdata[FPEC_CTL_ENABLE] & (op_state == FPEC_IDLE);
    assign latch_sel = ~new_free & new_latch;
    assign target_prot = new_region ? ~cfg_writable(flash_address) : (flash_address < WP_LIMIT);
    assign prot_err = start & ~latch_sel & target_prot;
    assign start_mem = start & ~latch_sel & ~target_prot;
    assign latch_load = start & latch_sel;
    // A read never shares the array with a running or starting operation
    assign rd_req = ctl_wr & pwdata[FPEC_CTL_READ] & ~read_start
        & (op_state == FPEC_IDLE) & ~start;

    assign mem_busy = (op_state == FPEC_ERASE) | (op_state == FPEC_PROGRAM);
    assign op_word = op_cnt[4:0];
    assign mem_step = mem_busy & (op_cnt < FPEC_CNT_W'(FPEC_ROW_WORDS));
    assign op_last = mem_busy & (op_cnt == FPEC_CNT_W'(FPEC_OP_CYCLES - 1));
    assign step_addr = {op_row, op_word};
    assign prog_idx = step_addr[ADDR_W-1:0];
    assign reset_err = first_cycle & busy_mark;

    // Every completed access moves it; only the ordered pattern advances
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_state <= FPEC_LOCKED;
        end else if (access) begin
            if (key_first) begin
                unlock_state <= FPEC_GOT_FIRST;
            end else if (key_second) begin
                unlock_state <= FPEC_ARMED;
            end else begin
                unlock_state <= FPEC_LOCKED;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_address <= FPEC_ADDR_RESET;
        end else if (wr_acc & sel_addr) begin
            if (pstrb[0]) begin
                flash_address[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                flash_address[14:8] <= pwdata[14:8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_data <= FPEC_DATA_RESET;
        end else if (read_start) begin
            flash_data <= next_read;
        end else if (wr_acc & sel_data) begin
            if (pstrb[0]) begin
                flash_data[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                flash_data[13:8] <= pwdata[13:8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            region_select <= FPEC_CTL_RESET[FPEC_CTL_REGION];
            latch_only <= FPEC_CTL_RESET[FPEC_CTL_LATCH];
            program_erase_enable <= FPEC_CTL_RESET[FPEC_CTL_ENABLE];
        end else if (ctl_wr) begin
            region_select <= pwdata[FPEC_CTL_REGION];
            latch_only <= pwdata[FPEC_CTL_LATCH];
            program_erase_enable <= pwdata[FPEC_CTL_ENABLE];
        end
    end

    // Sticky until the erase that it selects has finished
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_select <= FPEC_CTL_RESET[FPEC_CTL_ERASE];
        end else if (ctl_wr & pwdata[FPEC_CTL_ERASE]) begin
            erase_select <= 1'b1;
        end else if (op_last & (op_state == FPEC_ERASE)) begin
            erase_select <= 1'b0;
        end
    end

    // Set sources win over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_error_flag <= FPEC_CTL_RESET[FPEC_CTL_ERROR];
        end else if (prot_err | unlock_err | reset_err) begin
            write_error_flag <= 1'b1;
        end else if (ctl_wr) begin
            write_error_flag <= pwdata[FPEC_CTL_ERROR];
        end
    end

    // Only completion clears it, so a zero write cannot abort an operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_start <= FPEC_CTL_RESET[FPEC_CTL_WRITE];
        end else if (start_mem | latch_load) begin
            write_start <= 1'b1;
        end else if (op_last | (op_state == FPEC_LATCH)) begin
            write_start <= 1'b0;
        end
    end

    // One-cycle pulse; the word lands in the data register on the next edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_start <= FPEC_CTL_RESET[FPEC_CTL_READ];
        end else if (rd_req) begin
            read_start <= 1'b1;
        end else begin
            read_start <= 1'b0;
        end
    end

    // Latch load takes one cycle; erase and program run the full timed count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_state <= FPEC_IDLE;
            op_cnt <= '0;
            op_row <= '0;
            op_region <= 1'b0;
        end else begin
            unique case (op_state)
                FPEC_IDLE: begin
                    op_cnt <= '0;
                    if (latch_load) begin
                        op_state <= FPEC_LATCH;
                    end else if (start_mem) begin
                        op_state <= new_free ? FPEC_ERASE : FPEC_PROGRAM;
                        op_row <= flash_address[14:5];
                        op_region <= new_region;
                    end
                end
                FPEC_LATCH: begin
                    op_state <= FPEC_IDLE;
                end
                FPEC_ERASE, FPEC_PROGRAM: begin
                    op_cnt <= op_cnt + FPEC_CNT_W'(1);
                    if (op_last) begin
                        op_state <= FPEC_IDLE;
                    end
                end
            endcase
        end
    end

    // Remembers across a reset that an erase or program was cut short
    always_ff @(posedge pclk) begin
        if (presetn) begin
            busy_mark <= mem_busy;
        end
    end

    // High only up to the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end

    // Blank again after every erase or program, so unloaded latches program blank
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < FPEC_ROW_WORDS; i++) begin
                latch_mem[i] <= FPEC_BLANK;
            end
        end else if (op_last) begin
            for (int i = 0; i < FPEC_ROW_WORDS; i++) begin
                latch_mem[i] <= FPEC_BLANK;
            end
        end else if (op_state == FPEC_LATCH) begin
            latch_mem[flash_address[4:0]] <= flash_data;
        end
    end

    // Arrays carry no reset; one word per cycle keeps a single write port
    always_ff @(posedge pclk) begin
        if (mem_step & ~op_region) begin
            if (op_state == FPEC_ERASE) begin
                prog_mem[prog_idx] <= FPEC_BLANK;
            end else begin
                prog_mem[prog_idx] <= prog_mem[prog_idx] & latch_mem[op_word];
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (mem_step & op_region & cfg_writable(step_addr)) begin
            if (op_state == FPEC_ERASE) begin
                cfg_mem[op_word[3:0]] <= FPEC_BLANK;
            end else begin
                cfg_mem[op_word[3:0]] <= cfg_mem[op_word[3:0]] & latch_mem[op_word];
            end
        end
    end

    always_comb begin
        next_read = '0;
        if (!region_select) begin
            next_read = prog_mem[flash_address[ADDR_W-1:0]];
        end else if (cfg_writable(flash_address)) begin
            next_read = cfg_mem[flash_address[3:0]];
        end else if (flash_address == FPEC_CFG_DEVID) begin
            next_read = DEV_ID;
        end else if (flash_address == FPEC_CFG_REVID) begin
            next_read = REV_ID;
        end else if (flash_address >= FPEC_CFG_INFO_FIRST && flash_address <= FPEC_CFG_INFO_LAST) begin
            next_read = INFO_WORD;
        end
    end

    // Undefined bits are given as zero while writing, so reads stay deterministic
    always_comb begin
        next_prdata = '0;
        if (sel_addr) begin
            next_prdata = {17'h0, flash_address};
        end else if (sel_data) begin
            next_prdata = {18'h0, flash_data};
        end else if (sel_ctl) begin
            next_prdata = {24'h000000, 1'b0, region_select, latch_only, erase_select,
                write_error_flag & ~write_start, program_erase_enable, write_start, read_start};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup & ~pwrite) begin
            prdata <= next_prdata;
        end
    end

endmodule

`default_nettype wire

// [verification/flash_program_erase_control_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module flash_program_erase_control_tb import fpec_pkg::*; ;
    localparam logic [14:0] WP = 15'h0040;
    // Arbitrary identity value
    localparam logic [13:0] DEV_ID_TB = 14'h1357;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [13:0] mem [int];
    logic [13:0] lat [32];
    logic [14:0] la [3] = '{15'h0041, 15'h005F, 15'h0062};
    logic [13:0] dv;
    int fail_count, n_checks, cycles, seed;

    fpec_top #(.WP_LIMIT(WP), .DEV_ID(DEV_ID_TB)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Ops last 200 cycles; whole run is under two thousand
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd);
    endtask

    task automatic rdchk(input string name, input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd);
        check(name, exp, rd);
    endtask

    // Error bit always mirrors the model so writes never disturb it by accident
    function automatic logic [31:0] ctl(input logic [6:0] b);
        return {25'h0, b[6:4], err, b[2:0]};
    endfunction

    task automatic start(input logic [6:0] b);
        wr(FPEC_BA_UNLOCK, 32'h55);
        wr(FPEC_BA_UNLOCK, 32'hAA);
        wr(FPEC_BA_CONTROL, ctl(b));
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, FPEC_BA_CONTROL, 32'h0, rd);
            n++;
        end while (rd[1] !== 1'b0 && n < 200);
        check("op_done", 32'h0, {31'h0, rd[1]});
    endtask

    task automatic rdflash(input logic [14:0] a, input logic region, input logic [13:0] exp);
        wr(FPEC_BA_ADDRESS, {17'h0, a});
        wr(FPEC_BA_CONTROL, ctl({region, 6'h05}));
        rdchk("flash_word", FPEC_BA_DATA, {18'h0, exp});
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        seed = 32'hE00B64CC;
        err = 1'b0;
        foreach (lat[i]) lat[i] = FPEC_BLANK;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("control_reset", FPEC_BA_CONTROL, 32'h0);
        wr(FPEC_BA_ADDRESS, 32'hFFFFFFFF);
        rdchk("address_width", FPEC_BA_ADDRESS, 32'h7FFF);
        wr(FPEC_BA_DATA, 32'hFFFFFFFF);
        rdchk("data_width", FPEC_BA_DATA, 32'h3FFF);
        pstrb <= 4'h2;
        wr(FPEC_BA_DATA, 32'h0);
        pstrb <= 4'hF;
        rdchk("data_high_byte", FPEC_BA_DATA, 32'h00FF);
        apb(1'b0, 16'h7234, 32'h0, rd);
        check("unmapped_err", 32'h1, {31'h0, last_err});
        // Erase with latch-only set; a zero write to write-start mid-op
        wr(FPEC_BA_ADDRESS, 32'h4A);
        start(7'h36);
        wr(FPEC_BA_CONTROL, ctl(7'h24));
        rdchk("zero_write_ignored", FPEC_BA_CONTROL, 32'h36);
        wait_done();
        for (int i = 0; i < 32; i++) mem[64 + i] = FPEC_BLANK;
        rdflash(15'h0040, 1'b0, FPEC_BLANK);
        rdflash(15'h005F, 1'b0, FPEC_BLANK);
        // Latch loads, one from another row to show low bits pick the latch
        for (int i = 0; i < 3; i++) begin
            dv = 14'($random(seed));
            wr(FPEC_BA_ADDRESS, {17'h0, la[i]});
            wr(FPEC_BA_DATA, {18'h0, dv});
            start(7'h26);
            lat[la[i][4:0]] = dv;
        end
        wr(FPEC_BA_ADDRESS, 32'h45);
        start(7'h06);
        wait_done();
        for (int i = 0; i < 32; i++) begin
            mem[64 + i] = mem[64 + i] & lat[i];
            rdflash(15'(64 + i), 1'b0, mem[64 + i]);
            lat[i] = FPEC_BLANK;
        end
        // Latch loaded, then an erase must blank it before the row write
        wr(FPEC_BA_ADDRESS, 32'h41);
        wr(FPEC_BA_DATA, 32'h0);
        start(7'h26);
        start(7'h16);
        wait_done();
        start(7'h06);
        wait_done();
        rdflash(15'h0041, 1'b0, FPEC_BLANK);
        // Intervening read breaks the unlock pattern
        wr(FPEC_BA_UNLOCK, 32'h55);
        rdchk("unlock_read", FPEC_BA_UNLOCK, 32'h0);
        wr(FPEC_BA_UNLOCK, 32'hAA);
        wr(FPEC_BA_CONTROL, ctl(7'h06));
        err = 1'b1;
        rdchk("broken_unlock", FPEC_BA_CONTROL, ctl(7'h04));
        err = 1'b0;
        wr(FPEC_BA_CONTROL, ctl(7'h04));
        rdchk("error_clear", FPEC_BA_CONTROL, 32'h04);
        err = 1'b1;
        wr(FPEC_BA_CONTROL, ctl(7'h04));
        rdchk("error_set_sw", FPEC_BA_CONTROL, 32'h0C);
        err = 1'b0;
        wr(FPEC_BA_CONTROL, ctl(7'h00));
        start(7'h02);
        rdchk("enable_off", FPEC_BA_CONTROL, 32'h0);
        wr(FPEC_BA_ADDRESS, 32'h20);
        start(7'h06);
        err = 1'b1;
        rdchk("protected", FPEC_BA_CONTROL, 32'h0C);
        err = 1'b0;
        wr(FPEC_BA_CONTROL, ctl(7'h00));
        rdflash(15'h0005, 1'b1, DEV_ID_TB);
        rdflash(15'h0004, 1'b1, 14'h0);
        // Reset during an erase leaves the error mark
        wr(FPEC_BA_ADDRESS, 32'h60);
        start(7'h16);
        repeat (20) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("reset_in_op", FPEC_BA_CONTROL, 32'h08);
        wrap_up();
    end
endmodule
`default_nettype wire

// [verification/fpec_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module fpec_monitor import fpec_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    assign mapped = paddr == FPEC_BA_ADDRESS || paddr == FPEC_BA_DATA || paddr == FPEC_BA_CONTROL
        || paddr == FPEC_BA_UNLOCK;
    sequence read_setup_s(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    // Zero wait states keep the bus cycle count fixed
    ready_tied_a: assert property (pready) else $error("pready dropped");
    unmapped_err_a: assert property (access_s and !mapped |-> pslverr) else $error("unmapped access not refused");
    mapped_ok_a: assert property (access_s and mapped |-> !pslverr) else $error("mapped access refused");
    idle_err_a: assert property (!(psel && penable) |-> !pslverr) else $error("error outside access");
    rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    unmapped_data_a: assert property (psel && !penable && !pwrite && !mapped |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    addr_width_a: assert property (read_setup_s(FPEC_BA_ADDRESS) |=> prdata[31:15] == 17'h0)
        else $error("address upper bits set");
    data_width_a: assert property (read_setup_s(FPEC_BA_DATA) |=> prdata[31:14] == 18'h0)
        else $error("data upper bits set");
    unlock_read_a: assert property (read_setup_s(FPEC_BA_UNLOCK) |=> prdata == 32'h0)
        else $error("unlock register readable");
    ctrl_top_a: assert property (read_setup_s(FPEC_BA_CONTROL) |=> prdata[31:7] == 25'h0)
        else $error("control upper bits set");
endmodule
bind fpec_top fpec_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
`default_nettype wire
